// >>> hdl/flash_controller_pkg.sv
// flash controller package: register map, command codes, fields and timing
// Overview of operation
// - one fast bus port reads the array and fills the page buffer; peripheral port commands
// - 16 equal regions of pages, each guarded by its own lock fuse
// - whole-chip erase never touches the user page
// - user page written or erased only by its own commands; read like the array
// - each fast bus read returns the addressed 32-bit word
// - zero-wait mode gives one word per clock, stalling only while a command runs
// - wait-state mode stalls and reads the array 64 bits at a time
// - status bits 31..16 show each region's lock, 1 when locked
// - status bit 6 shows fast mode enabled
// - status bit 5 holds last quick page read result, 1 when erased
// - status bit 4 shows the security bit
// - status bit 3 sets on bad command or key, clears on status read
// - status bit 2 sets on page write or erase in a locked region, or chip erase with any lock set, clears on status read
// - status bit 0 is 0 while busy, 1 when ready for a command
// - debug halt of the processor does not disturb the controller
package flash_controller_pkg;
   // peripheral port register offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   // control register fields
   localparam int CTRL_WAIT_BIT = 0;
   localparam int CTRL_FAST_BIT = 6;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // status register fields
   localparam int ST_LOCK_LSB = 16;
   localparam int ST_FAST_BIT = 6;
   localparam int ST_QUICK_PAGE_READ_RESULT_BIT = 5;
   localparam int ST_SEC_BIT = 4;
   localparam int ST_CMDERR_BIT = 3;
   localparam int ST_LOCKERR_BIT = 2;
   localparam int ST_READY_BIT = 0;
   // command word fields
   localparam int CMD_KEY_LSB = 24;
   localparam int CMD_PAGE_LSB = 8;
   localparam logic [7:0] CMD_KEY = 8'hA5;
   localparam logic [5:0] OP_NOP = 6'h00;
   localparam logic [5:0] OP_WRITE_PAGE = 6'h01;
   localparam logic [5:0] OP_ERASE_PAGE = 6'h02;
   localparam logic [5:0] OP_CLEAR_BUF = 6'h03;
   localparam logic [5:0] OP_ERASE_ALL = 6'h05;
   localparam logic [5:0] OP_QUICK_READ = 6'h0C;
   localparam logic [5:0] OP_WRITE_USER = 6'h0D;
   localparam logic [5:0] OP_ERASE_USER = 6'h0E;
   // geometry: byte address bit 17 selects the user page
   localparam int ADDR_W = 18;
   localparam int USER_BIT = 17;
   localparam int DW_W = 14;
   localparam int PAGE_W = 8;
   localparam int REGIONS = 16;
   localparam int BUF_IDX_W = 7;
   // array access time and derived wait states
   localparam int CLK_PERIOD_NS = 25;
   localparam int ACCESS_NS = 40;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] WAIT_STATES = 4'(ACCESS_CYC - 1);
endpackage : flash_controller_pkg

// >>> hdl/flash_controller.sv
// flash controller: fast bus read path, page buffer fill, command sequencer, status
`timescale 1ns/100ps
`default_nettype none
module flash_controller (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic hs_req_i,
   input wire logic hs_write_i,
   input wire logic [17:0] hs_addr_i,
   input wire logic [31:0] hs_wdata_i,
   output logic hs_ready_o,
   output logic hs_rvalid_o,
   output logic [31:0] hs_rdata_o,
   input wire logic pb_sel_i,
   input wire logic pb_write_i,
   input wire logic [7:0] pb_addr_i,
   input wire logic [31:0] pb_wdata_i,
   output logic [31:0] pb_rdata_o,
   input wire logic [15:0] lock_fuse_i,
   input wire logic security_i,
   output logic [13:0] arr_raddr_o,
   output logic arr_ruser_o,
   input wire logic [63:0] arr_rdata_i,
   output logic pbuf_we_o,
   output logic [6:0] pbuf_idx_o,
   output logic [31:0] pbuf_wdata_o,
   output logic arr_start_o,
   output logic [5:0] arr_op_o,
   output logic [7:0] arr_page_o,
   output logic arr_user_o,
   input wire logic arr_done_i,
   input wire logic arr_erased_i
);
   typedef enum logic {RD_IDLE, RD_WAIT} rd_state_t;
   typedef enum logic {CMD_IDLE, CMD_RUN} cmd_state_t;

   // pick the addressed half of a 64-bit line
   function automatic logic [31:0] half_sel(input logic [63:0] line, input logic hi);
      half_sel = hi ? line[63:32] : line[31:0];
   endfunction : half_sel

   function automatic logic op_known(input logic [5:0] op);
      op_known = (op == flash_controller_pkg::OP_WRITE_PAGE) ||
         (op == flash_controller_pkg::OP_ERASE_PAGE) ||
         (op == flash_controller_pkg::OP_CLEAR_BUF) ||
         (op == flash_controller_pkg::OP_ERASE_ALL) ||
         (op == flash_controller_pkg::OP_QUICK_READ) ||
         (op == flash_controller_pkg::OP_WRITE_USER) ||
         (op == flash_controller_pkg::OP_ERASE_USER);
   endfunction : op_known

   rd_state_t rd_state, next_rd_state;
   cmd_state_t cmd_state, next_cmd_state;
   logic [3:0] rd_cnt, next_rd_cnt;
   logic rd_hi, next_rd_hi;
   logic [13:0] next_raddr;
   logic next_ruser, next_ready, next_rvalid;
   logic [31:0] next_rdata;
   logic [63:0] buf_data, next_buf_data;
   logic [14:0] buf_tag, next_buf_tag;
   logic buf_valid, next_buf_valid;
   logic next_pbuf_we;
   logic [6:0] next_pbuf_idx;
   logic [31:0] next_pbuf_wdata;
   logic [31:0] ctrl, next_ctrl;
   logic cmd_err, next_cmd_err, lock_err, next_lock_err, quick_page_read_result, next_quick_page_read_result;
   logic next_start, next_user;
   logic [5:0] next_op;
   logic [7:0] next_page;
   logic [31:0] next_pb_rdata;
   logic wait_en, rd_take, rd_hit, rd_finish, st_read, cmd_take, set_cmd_err, set_lock_err;
   logic [5:0] cmd_op;
   logic [7:0] cmd_page;

   assign wait_en = ctrl[flash_controller_pkg::CTRL_WAIT_BIT];
   assign rd_take = hs_req_i && hs_ready_o && !hs_write_i;
   assign rd_hit = wait_en && buf_valid && (buf_tag == {hs_addr_i[17], hs_addr_i[16:3]});
   assign rd_finish = (rd_state == RD_WAIT) && (rd_cnt == 4'h0);
   assign st_read = pb_sel_i && !pb_write_i && (pb_addr_i == flash_controller_pkg::OFF_STATUS);
   assign cmd_take = pb_sel_i && pb_write_i && (pb_addr_i == flash_controller_pkg::OFF_CMD) &&
      (cmd_state == CMD_IDLE);
   assign cmd_op = pb_wdata_i[5:0];
   assign cmd_page = pb_wdata_i[flash_controller_pkg::CMD_PAGE_LSB +: 8];

   // read path: user page reads use the same path, bit 17 just goes with the address
   always_comb begin
      next_rd_state = rd_state;
      next_rd_cnt = rd_cnt;
      next_rd_hi = rd_hi;
      next_raddr = arr_raddr_o;
      next_ruser = arr_ruser_o;
      next_rdata = hs_rdata_o;
      next_rvalid = 1'b0;
      next_buf_data = buf_data;
      next_buf_tag = buf_tag;
      next_buf_valid = buf_valid && !next_start; // array contents may change under a command
      if (rd_state == RD_WAIT && rd_cnt != 4'h0) begin
         next_rd_cnt = rd_cnt - 4'h1;
      end
      if (rd_finish) begin
         next_buf_data = arr_rdata_i;
         next_buf_tag = {arr_ruser_o, arr_raddr_o};
         next_buf_valid = !next_start;
         next_rdata = half_sel(arr_rdata_i, rd_hi);
         next_rvalid = 1'b1;
         next_rd_state = RD_IDLE;
      end
      if (rd_take) begin
         if (rd_hit) begin
            next_rdata = half_sel(buf_data, hs_addr_i[2]);
            next_rvalid = 1'b1;
         end else begin
            next_raddr = hs_addr_i[16:3];
            next_ruser = hs_addr_i[flash_controller_pkg::USER_BIT];
            next_rd_hi = hs_addr_i[2];
            next_rd_cnt = wait_en ? flash_controller_pkg::WAIT_STATES : 4'h0;
            next_rd_state = RD_WAIT;
         end
      end
      // both modes drop ready while a command runs; wait mode also holds it low until data returns
      next_ready = !(wait_en && next_rd_state == RD_WAIT) && (next_cmd_state == CMD_IDLE);
      next_pbuf_we = hs_req_i && hs_ready_o && hs_write_i;
      next_pbuf_idx = hs_addr_i[8:2];
      next_pbuf_wdata = hs_wdata_i;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_state <= RD_IDLE;
         rd_cnt <= 4'h0;
         rd_hi <= 1'b0;
         arr_raddr_o <= 14'h0000;
         arr_ruser_o <= 1'b0;
         hs_rdata_o <= 32'h0000_0000;
         hs_rvalid_o <= 1'b0;
         hs_ready_o <= 1'b1;
         buf_data <= 64'h0000_0000_0000_0000;
         buf_tag <= 15'h0000;
         buf_valid <= 1'b0;
         pbuf_we_o <= 1'b0;
         pbuf_idx_o <= 7'h00;
         pbuf_wdata_o <= 32'h0000_0000;
      end else begin
         rd_state <= next_rd_state;
         rd_cnt <= next_rd_cnt;
         rd_hi <= next_rd_hi;
         arr_raddr_o <= next_raddr;
         arr_ruser_o <= next_ruser;
         hs_rdata_o <= next_rdata;
         hs_rvalid_o <= next_rvalid;
         hs_ready_o <= next_ready;
         buf_data <= next_buf_data;
         buf_tag <= next_buf_tag;
         buf_valid <= next_buf_valid;
         pbuf_we_o <= next_pbuf_we;
         pbuf_idx_o <= next_pbuf_idx;
         pbuf_wdata_o <= next_pbuf_wdata;
      end
   end

   // command sequencer and status; no debug input exists, so a halted cpu changes nothing
   always_comb begin
      next_cmd_state = cmd_state;
      next_start = 1'b0;
      next_op = arr_op_o;
      next_page = arr_page_o;
      next_user = arr_user_o;
      next_quick_page_read_result = quick_page_read_result;
      next_ctrl = ctrl;
      set_cmd_err = 1'b0;
      set_lock_err = 1'b0;
      if (pb_sel_i && pb_write_i && pb_addr_i == flash_controller_pkg::OFF_CTRL) begin
         next_ctrl = pb_wdata_i & 32'h0000_0041;
      end
      if (cmd_take) begin
         if (pb_wdata_i[flash_controller_pkg::CMD_KEY_LSB +: 8] != flash_controller_pkg::CMD_KEY ||
               !op_known(cmd_op)) begin
            set_cmd_err = 1'b1;
         end else if (((cmd_op == flash_controller_pkg::OP_WRITE_PAGE ||
               cmd_op == flash_controller_pkg::OP_ERASE_PAGE) && lock_fuse_i[cmd_page[7:4]]) ||
               (cmd_op == flash_controller_pkg::OP_ERASE_ALL && lock_fuse_i != 16'h0000)) begin
            set_lock_err = 1'b1;
         end else begin
            next_start = 1'b1;
            next_op = cmd_op;
            next_page = cmd_page;
            // only the dedicated commands reach the user page, so chip erase spares it
            next_user = (cmd_op == flash_controller_pkg::OP_WRITE_USER) ||
               (cmd_op == flash_controller_pkg::OP_ERASE_USER);
            next_cmd_state = CMD_RUN;
         end
      end
      if (cmd_state == CMD_RUN && arr_done_i) begin
         next_cmd_state = CMD_IDLE;
         if (arr_op_o == flash_controller_pkg::OP_QUICK_READ) begin
            next_quick_page_read_result = arr_erased_i;
         end
      end
      // a new error in the same cycle as the clearing read survives it
      next_cmd_err = set_cmd_err || (cmd_err && !st_read);
      next_lock_err = set_lock_err || (lock_err && !st_read);
      next_pb_rdata = 32'h0000_0000;
      if (pb_sel_i && !pb_write_i) begin
         unique case (pb_addr_i)
            flash_controller_pkg::OFF_CTRL: next_pb_rdata = ctrl;
            flash_controller_pkg::OFF_STATUS: begin
               next_pb_rdata[flash_controller_pkg::ST_LOCK_LSB +: 16] = lock_fuse_i;
               next_pb_rdata[flash_controller_pkg::ST_FAST_BIT] =
                  ctrl[flash_controller_pkg::CTRL_FAST_BIT];
               next_pb_rdata[flash_controller_pkg::ST_QUICK_PAGE_READ_RESULT_BIT] = quick_page_read_result;
               next_pb_rdata[flash_controller_pkg::ST_SEC_BIT] = security_i;
               next_pb_rdata[flash_controller_pkg::ST_CMDERR_BIT] = cmd_err;
               next_pb_rdata[flash_controller_pkg::ST_LOCKERR_BIT] = lock_err;
               next_pb_rdata[flash_controller_pkg::ST_READY_BIT] = (cmd_state == CMD_IDLE);
            end
            default: next_pb_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_state <= CMD_IDLE;
         arr_start_o <= 1'b0;
         arr_op_o <= flash_controller_pkg::OP_NOP;
         arr_page_o <= 8'h00;
         arr_user_o <= 1'b0;
         quick_page_read_result <= 1'b0;
         cmd_err <= 1'b0;
         lock_err <= 1'b0;
         ctrl <= flash_controller_pkg::CTRL_RESET;
         pb_rdata_o <= 32'h0000_0000;
      end else begin
         cmd_state <= next_cmd_state;
         arr_start_o <= next_start;
         arr_op_o <= next_op;
         arr_page_o <= next_page;
         arr_user_o <= next_user;
         quick_page_read_result <= next_quick_page_read_result;
         cmd_err <= next_cmd_err;
         lock_err <= next_lock_err;
         ctrl <= next_ctrl;
         pb_rdata_o <= next_pb_rdata;
      end
   end

   default clocking dflt_cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_ZERO_WAIT_READ: assert property ((rd_take && !wait_en && !rd_hit) |->
      ##2 hs_rvalid_o)
      else $error("zero-wait read did not return in two cycles");
   AST_WAIT_STALL: assert property ((rd_take && wait_en && !rd_hit) |=>
      (rd_state == RD_WAIT && rd_cnt == flash_controller_pkg::WAIT_STATES) ##1 !hs_ready_o)
      else $error("wait-state read did not stall");
   // half select of the finishing read: a streamed take in that cycle moves rd_hi on
   AST_READ_WORD: assert property (rd_finish |=>
      hs_rdata_o == half_sel($past(arr_rdata_i), $past(rd_hi)))
      else $error("returned word is not the addressed half");
   AST_LOCK_BITS: assert property (st_read |=> pb_rdata_o[31:16] == $past(lock_fuse_i))
      else $error("lock status bits wrong");
   AST_CMDERR_SET: assert property (set_cmd_err |=> cmd_err && !arr_start_o)
      else $error("bad command not flagged");
   AST_CMDERR_CLEAR: assert property ((st_read && cmd_err && !set_cmd_err) |=>
      !cmd_err ##0 pb_rdata_o[3])
      else $error("command error not cleared by read");
   AST_LOCKERR: assert property ((st_read && lock_err && !set_lock_err) |=>
      !lock_err ##0 pb_rdata_o[2])
      else $error("lock error not cleared by read");
   AST_BUSY_BIT: assert property ((st_read && cmd_state == CMD_RUN) |=> !pb_rdata_o[0])
      else $error("ready bit high while busy");
   AST_USER_SAFE: assert property ((arr_start_o &&
      arr_op_o == flash_controller_pkg::OP_ERASE_ALL) |-> !arr_user_o)
      else $error("chip erase selected the user page");
   AST_RESERVED: assert property (st_read |=>
      pb_rdata_o[15:7] == 9'h000 && !pb_rdata_o[1])
      else $error("reserved status bits not zero");
   AST_QUICK_PAGE_READ_RESULT: assert property ((cmd_state == CMD_RUN && arr_done_i &&
      arr_op_o == flash_controller_pkg::OP_QUICK_READ) |=> quick_page_read_result == $past(arr_erased_i))
      else $error("quick read result not held");

   COV_ZERO_WAIT_STREAM: cover property (rd_take && !wait_en ##1 rd_take ##1 rd_take);
   COV_BUFFER_HIT: cover property (rd_take && rd_hit);
   COV_CMD_DONE: cover property (arr_start_o ##[1:20] (cmd_state == CMD_RUN && arr_done_i));
   COV_LOCK_REFUSED: cover property (set_lock_err);
endmodule : flash_controller
`default_nettype wire

// >>> sim/flash_array_model.sv
// array model: combinational read line and timed command completion
`timescale 1ns/100ps
`default_nettype none
module flash_array_model #(
   parameter int FAST_CYC = 2,
   parameter int SLOW_CYC = 12
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic slow_i,
   input wire logic [13:0] raddr_i,
   input wire logic ruser_i,
   output logic [63:0] rdata_o,
   input wire logic start_i,
   input wire logic [7:0] page_i,
   output var logic done_o,
   output logic erased_o
);
   int count;
   logic busy;
   // each half carries the line address and its own marker byte so a wrong half or stale line shows
   assign rdata_o = {8'hC3, ruser_i, 9'h000, raddr_i, 8'h5A, ruser_i, 9'h000, raddr_i};
   // result only meaningful with done; inverted otherwise so a stray sample fails
   assign erased_o = done_o ? ~page_i[0] : page_i[0];
   // command timer, prompt or slow as the bench asks
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy <= 1'b0;
         count <= 0;
         done_o <= 1'b0;
      end else begin
         done_o <= busy && count == 1;
         if (start_i) begin
            busy <= 1'b1;
            count <= slow_i ? SLOW_CYC : FAST_CYC;
         end else if (busy) begin
            busy <= count > 1;
            count <= count - 1;
         end
      end
   end
endmodule : flash_array_model
`default_nettype wire

// >>> sim/embedded_flash_controller_test.sv
// testbench: fast bus reads, page buffer writes, commands and status
`timescale 1ns/100ps
`default_nettype none
module embedded_flash_controller_test;
   logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, hwr = 1'b0, sel = 1'b0, pwr = 1'b0;
   logic [17:0] haddr = 18'h00000;
   logic [31:0] hwd = 32'h00000000, pwd = 32'h00000000, q;
   logic [7:0] paddr = 8'h00;
   logic [15:0] lock = 16'h8001;
   logic sec = 1'b1, slow = 1'b0, fast = 1'b0, quick_page_read_result = 1'b0;
   logic usr_exp;
   logic rdy, rv, pwe, st_o, usr, ruser, done, ers;
   logic [31:0] rd, prd, pbwd;
   logic [13:0] raddr;
   logic [63:0] line;
   logic [6:0] idx;
   logic [5:0] op;
   logic [7:0] pg;
   logic [5:0] ops [7];
   int num_errors = 0, total_checks = 0, lat, n;
   flash_controller flash_controller_i (.core_clk_i(clk), .rst_n_i(rst_n), .hs_req_i(req),
      .hs_write_i(hwr), .hs_addr_i(haddr), .hs_wdata_i(hwd), .hs_ready_o(rdy),
      .hs_rvalid_o(rv), .hs_rdata_o(rd), .pb_sel_i(sel), .pb_write_i(pwr), .pb_addr_i(paddr),
      .pb_wdata_i(pwd), .pb_rdata_o(prd), .lock_fuse_i(lock), .security_i(sec),
      .arr_raddr_o(raddr), .arr_ruser_o(ruser), .arr_rdata_i(line), .pbuf_we_o(pwe),
      .pbuf_idx_o(idx), .pbuf_wdata_o(pbwd), .arr_start_o(st_o), .arr_op_o(op),
      .arr_page_o(pg), .arr_user_o(usr), .arr_done_i(done), .arr_erased_i(ers));
   flash_array_model flash_array_model_i (.core_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
      .raddr_i(raddr), .ruser_i(ruser), .rdata_o(line), .start_i(st_o), .page_i(pg),
      .done_o(done), .erased_o(ers));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   // one strobe cycle; read data is taken the cycle after the strobe
   task automatic pb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      sel = 1'b1;
      pwr = w;
      paddr = a;
      pwd = d;
      @(negedge clk);
      q = prd;
      sel = 1'b0;
   endtask : pb
   function automatic logic [31:0] stv(input logic r, input logic e3, input logic e2);
      return {lock, 8'h00, 1'b0, fast, quick_page_read_result, sec, e3, e2, 1'b0, r};
   endfunction : stv
   task automatic st(input logic [31:0] exp);
      pb(1'b0, flash_controller_pkg::OFF_STATUS, 32'h0);
      check(q, exp);
   endtask : st
   task automatic cmd(input logic [7:0] k, input logic [7:0] p, input logic [5:0] o);
      pb(1'b1, flash_controller_pkg::OFF_CMD, {k, 8'h00, p, 2'b00, o});
   endtask : cmd
   // request held until taken; lat counts edges from take to the answer
   task automatic hs(input logic w, input logic [17:0] a, input logic [31:0] d);
      @(negedge clk);
      req = 1'b1;
      hwr = w;
      haddr = a;
      hwd = d;
      lat = 0;
      while (rdy !== 1'b1 && lat < 50) begin
         @(negedge clk);
         lat++;
      end
      lat = 1;
      @(negedge clk);
      req = 1'b0;
      while ((w ? pwe : rv) !== 1'b1 && lat < 20) begin
         @(negedge clk);
         lat++;
      end
   endtask : hs
   function automatic logic [31:0] word(input logic [17:0] a);
      return {a[2] ? 8'hC3 : 8'h5A, a[17], 9'h000, a[16:3]};
   endfunction : word
   initial begin
      #100000;
      num_errors++;
      stop_test();
   end
   initial begin
      ops = '{6'h01, 6'h02, 6'h03, 6'h0C, 6'h0D, 6'h0E, 6'h05};
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      st(stv(1'b1, 1'b0, 1'b0));
      pb(1'b1, flash_controller_pkg::OFF_STATUS, 32'hFFFFFFFF);
      st(stv(1'b1, 1'b0, 1'b0));
      pb(1'b0, 8'h40, 32'h0);
      check(q, 32'h00000000);
      $display("test registers done");
      hs(1'b0, 18'h00010, 32'h0);
      check(32'(lat), 32'h2);
      check(rd, word(18'h00010));
      hs(1'b0, 18'h20014, 32'h0);
      check(rd, word(18'h20014));
      pb(1'b1, flash_controller_pkg::OFF_CTRL, 32'h00000041);
      fast = 1'b1;
      st(stv(1'b1, 1'b0, 1'b0));
      hs(1'b0, 18'h00108, 32'h0);
      check(32'(lat), 32'h3);
      check(rd, word(18'h00108));
      hs(1'b0, 18'h0010C, 32'h0);
      check(32'(lat), 32'h1);
      check(rd, word(18'h0010C));
      hs(1'b1, 18'h00024, 32'hDEADBEEF);
      check(32'(lat), 32'h1);
      check({25'h0, idx}, {25'h0, 7'h09});
      check(pbwd, 32'hDEADBEEF);
      $display("test fast bus done");
      slow = 1'b1;
      cmd(8'h00, 8'h12, 6'h01);
      st(stv(1'b1, 1'b1, 1'b0));
      st(stv(1'b1, 1'b0, 1'b0));
      cmd(flash_controller_pkg::CMD_KEY, 8'h12, 6'h3F);
      st(stv(1'b1, 1'b1, 1'b0));
      cmd(flash_controller_pkg::CMD_KEY, 8'hF0, 6'h02);
      st(stv(1'b1, 1'b0, 1'b1));
      st(stv(1'b1, 1'b0, 1'b0));
      cmd(flash_controller_pkg::CMD_KEY, 8'h12, 6'h05);
      st(stv(1'b1, 1'b0, 1'b1));
      $display("test errors done");
      // prompt and slow completions alternate; chip erase last, once every fuse is open
      for (int i = 0; i < 7; i++) begin
         slow = i[0];
         if (ops[i] == 6'h05) lock = 16'h0000;
         cmd(flash_controller_pkg::CMD_KEY, 8'h12, ops[i]);
         usr_exp = (ops[i] == 6'h0D) || (ops[i] == 6'h0E);
         check({29'h0, st_o, rdy, usr}, {29'h0, 2'b10, usr_exp});
         check({18'h0, op, pg}, {18'h0, ops[i], 8'h12});
         if (slow) st(stv(1'b0, 1'b0, 1'b0));
         n = 0;
         q = 32'h0;
         while (q[0] !== 1'b1 && n < 30) begin
            pb(1'b0, flash_controller_pkg::OFF_STATUS, 32'h0);
            n++;
         end
         if (ops[i] == 6'h0C) quick_page_read_result = 1'b1;
         st(stv(1'b1, 1'b0, 1'b0));
      end
      sec = 1'b0;
      st(stv(1'b1, 1'b0, 1'b0));
      // the commands must have dropped the line buffer, so this read misses again
      hs(1'b0, 18'h0010C, 32'h0);
      check(32'(lat), 32'h3);
      check(rd, word(18'h0010C));
      $display("test commands done");
      stop_test();
   end
endmodule : embedded_flash_controller_test
`default_nettype wire
